/* src/fault_vid_pkg.sv */
// shared offsets, field positions, reset values and timing of the fault and voltage-id bank
package fault_vid_pkg;
   // register offsets
   localparam logic [7:0] CFG_ONE_ADDR = 8'h40;
   localparam logic [7:0] FAULT_STATUS_SECOND_ADDR = 8'h42;
   localparam logic [7:0] VOLTAGE_ID_GPIO_ADDR = 8'h43;
   localparam logic [7:0] CFG_FIVE_ADDR = 8'h7c;
   // reset values
   localparam logic [7:0] CFG_ONE_RESET = 8'h00;
   localparam logic [7:0] FAULT_STATUS_SECOND_RESET = 8'h00;
   localparam logic [7:0] VOLTAGE_ID_GPIO_RESET = 8'h1f;
   localparam logic [7:0] CFG_FIVE_RESET = 8'h00;
   // configuration one fields
   localparam int MONITOR_START_BIT = 0;
   localparam int CFG_LOCK_BIT = 1;
   // configuration five field
   localparam int ID_GPIO_MODE_BIT = 4;
   // fault status fields
   localparam int TWELVE_OR_CHANGE_BIT = 0;
   localparam int OVERTEMP_BIT = 1;
   localparam int FAN_ONE_BIT = 2;
   localparam int FOURTH_FAN_OR_PIN_BIT = 5;
   localparam int DIODE_ONE_BIT = 6;
   localparam int DIODE_TWO_BIT = 7;
   // voltage-id register fields
   localparam int ID_TOP_BIT = 5;
   localparam int ID_THRESHOLD_BIT = 6;
   localparam int SHARED_PIN_SELECT_BIT = 7;
   // change-compare window
   localparam int CLK_PERIOD_NS = 100;
   localparam int ID_WINDOW_NS = 11000;
   localparam int ID_WINDOW_CYCLES = (ID_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ID_COUNT_W = 8;
   // function of the multi-function pin
   typedef enum logic [3:0] {
      PIN_TACH = 4'b0001,
      PIN_GPIO_OUT = 4'b0010,
      PIN_GPIO_IN = 4'b0100,
      PIN_THERMAL_TIMER = 4'b1000
   } pin_mode_t;
endpackage

/* src/sticky_flag.sv */
// one sticky fault flag with set-over-clear and clear on status read
module sticky_flag
   import fault_vid_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // condition
   input wire logic set_cond,
   input wire logic clear_ok,
   input wire logic status_read,
   // flag
   output logic flag_q
);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (set_cond) begin
         // a fresh event beats a read that would clear
         flag_q <= 1'b1;
      end else if (status_read && clear_ok) begin
         flag_q <= 1'b0;
      end
   end
endmodule // sticky_flag

/* src/id_change_detect.sv */
// voltage-id change detector against a snapshot refreshed every compare window
module id_change_detect
   import fault_vid_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // pins and mode
   input wire logic [5:0] id_pins,
   input wire logic top_bit_used,
   // result
   output logic changed_q
);
   logic [ID_COUNT_W-1:0] count_q;
   logic [5:0] snap_q;
   logic [5:0] cur;

   // sixth level only counts while the shared pin carries it
   assign cur = {id_pins[5] & top_bit_used, id_pins[4:0]};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (count_q == ID_COUNT_W'(ID_WINDOW_CYCLES - 1)) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end

   // snapshot is at most one window old, so a change shows within one window
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_q <= 6'h00;
      end else if (count_q == ID_COUNT_W'(ID_WINDOW_CYCLES - 1)) begin
         snap_q <= cur;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         changed_q <= 1'b0;
      end else begin
         changed_q <= (cur != snap_q);
      end
   end
endmodule // id_change_detect

/* src/fault_status_and_vid_port.sv */
// second fault status register and voltage-id / gpio register behind the smbus register port
module fault_status_and_vid_port
   import fault_vid_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port from the smbus slave
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   // fault conditions from the monitor
   input wire logic twelve_volt_violation,
   input wire logic overtemp_exceeded,
   input wire logic overtemp_below_hysteresis,
   input wire logic [3:0] fan_slow,
   input wire logic [2:0] fan_drive_off,
   input wire logic thermal_timer_over,
   input wire logic [1:0] diode_fault,
   input wire pin_mode_t fourth_pin_mode,
   // voltage-id pins, bit 5 on the shared pin
   input wire logic [5:0] voltage_id_in,
   output logic [4:0] voltage_id_out,
   output logic [4:0] voltage_id_oe,
   // general pin six
   input wire logic general_pin_six_in,
   output logic general_pin_six_out,
   output logic general_pin_six_oe,
   // controls and summaries
   output logic monitor_start,
   output logic fan_full_duty,
   output logic id_threshold_select,
   output logic shared_pin_function_select,
   output logic out_of_limit_summary,
   output logic id_change_alert
);
   logic [7:0] cfg_one_q;
   logic [7:0] cfg_five_q;
   logic [7:0] id_reg_q;
   logic pin_six_q;
   logic [7:0] flag_set;
   logic [7:0] flag_clr_ok;
   logic [7:0] flags_q;
   logic [7:0] status_view;
   logic [7:0] id_view;
   logic status_read;
   logic id_changed;
   logic wr_cfg_one;

   assign status_read = reg_rd && (reg_addr == FAULT_STATUS_SECOND_ADDR);
   assign wr_cfg_one = reg_wr && (reg_addr == CFG_ONE_ADDR);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_one_q <= CFG_ONE_RESET;
      end else if (wr_cfg_one) begin
         if (cfg_one_q[CFG_LOCK_BIT]) begin
            cfg_one_q[MONITOR_START_BIT] <= reg_wdata[MONITOR_START_BIT];
         end else begin
            cfg_one_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_five_q <= CFG_FIVE_RESET;
      end else if (reg_wr && reg_addr == CFG_FIVE_ADDR) begin
         cfg_five_q <= reg_wdata;
      end
   end

   // id register keeps output levels, threshold and shared-pin select
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         id_reg_q <= VOLTAGE_ID_GPIO_RESET;
      end else if (reg_wr && reg_addr == VOLTAGE_ID_GPIO_ADDR) begin
         id_reg_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_six_q <= 1'b0;
      end else if (reg_wr && reg_addr == FAULT_STATUS_SECOND_ADDR
                   && fourth_pin_mode == PIN_GPIO_OUT) begin
         pin_six_q <= reg_wdata[FOURTH_FAN_OR_PIN_BIT];
      end
   end

   assign monitor_start = cfg_one_q[MONITOR_START_BIT];
   assign fan_full_duty = !cfg_one_q[MONITOR_START_BIT];
   assign id_threshold_select = id_reg_q[ID_THRESHOLD_BIT];
   assign shared_pin_function_select = id_reg_q[SHARED_PIN_SELECT_BIT];
   assign voltage_id_out = id_reg_q[4:0];
   assign voltage_id_oe = {5{cfg_five_q[ID_GPIO_MODE_BIT]}};
   assign general_pin_six_out = pin_six_q;
   assign general_pin_six_oe = (fourth_pin_mode == PIN_GPIO_OUT);

   id_change_detect u_id_change (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .id_pins(voltage_id_in),
      .top_bit_used(id_reg_q[SHARED_PIN_SELECT_BIT]),
      .changed_q(id_changed)
   );

   always_comb begin
      flag_set = 8'h00;
      flag_clr_ok = 8'h00;
      if (id_reg_q[SHARED_PIN_SELECT_BIT]) begin
         flag_set[TWELVE_OR_CHANGE_BIT] = id_changed;
         flag_clr_ok[TWELVE_OR_CHANGE_BIT] = !id_changed;
      end else begin
         flag_set[TWELVE_OR_CHANGE_BIT] = twelve_volt_violation;
         flag_clr_ok[TWELVE_OR_CHANGE_BIT] = !twelve_volt_violation;
      end
      flag_set[OVERTEMP_BIT] = overtemp_exceeded;
      flag_clr_ok[OVERTEMP_BIT] = overtemp_below_hysteresis;
      // fans one to three gated by drive
      for (int i = 0; i < 3; i++) begin
         flag_set[FAN_ONE_BIT + i] = fan_slow[i] && !fan_drive_off[i];
         flag_clr_ok[FAN_ONE_BIT + i] = !fan_slow[i];
      end
      // fan four gated by third drive
      unique case (fourth_pin_mode)
         PIN_TACH: begin
            flag_set[FOURTH_FAN_OR_PIN_BIT] = fan_slow[3] && !fan_drive_off[2];
            flag_clr_ok[FOURTH_FAN_OR_PIN_BIT] = !fan_slow[3];
         end
         PIN_THERMAL_TIMER: begin
            flag_set[FOURTH_FAN_OR_PIN_BIT] = thermal_timer_over;
            flag_clr_ok[FOURTH_FAN_OR_PIN_BIT] = !thermal_timer_over;
         end
         // gpio modes own the bit, so any stale flag drains on the next read
         default: begin
            flag_clr_ok[FOURTH_FAN_OR_PIN_BIT] = 1'b1;
         end
      endcase
      flag_set[DIODE_ONE_BIT] = diode_fault[0];
      flag_clr_ok[DIODE_ONE_BIT] = !diode_fault[0];
      flag_set[DIODE_TWO_BIT] = diode_fault[1];
      flag_clr_ok[DIODE_TWO_BIT] = !diode_fault[1];
   end

   for (genvar g = 0; g < 8; g++) begin : g_flag
      sticky_flag u_flag (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .set_cond(flag_set[g]),
         .clear_ok(flag_clr_ok[g]),
         .status_read(status_read),
         .flag_q(flags_q[g])
      );
   end

   // bit 5 shows the pin in gpio modes
   always_comb begin
      status_view = flags_q;
      if (fourth_pin_mode == PIN_GPIO_IN) begin
         status_view[FOURTH_FAN_OR_PIN_BIT] = general_pin_six_in;
      end else if (fourth_pin_mode == PIN_GPIO_OUT) begin
         status_view[FOURTH_FAN_OR_PIN_BIT] = pin_six_q;
      end
   end

   assign out_of_limit_summary = |(flags_q & ~{2'b00,
      (fourth_pin_mode == PIN_GPIO_IN || fourth_pin_mode == PIN_GPIO_OUT), 5'b00000});
   assign id_change_alert = flags_q[TWELVE_OR_CHANGE_BIT] && id_reg_q[SHARED_PIN_SELECT_BIT];

   // top id bit gated by select
   assign id_view = {id_reg_q[7:6],
                     voltage_id_in[5] & id_reg_q[SHARED_PIN_SELECT_BIT],
                     voltage_id_in[4:0]};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            CFG_ONE_ADDR: reg_rdata_q <= cfg_one_q;
            FAULT_STATUS_SECOND_ADDR: reg_rdata_q <= status_view;
            VOLTAGE_ID_GPIO_ADDR: reg_rdata_q <= id_view;
            CFG_FIVE_ADDR: reg_rdata_q <= cfg_five_q;
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   start_locked_a: assert property (
      wr_cfg_one && cfg_one_q[CFG_LOCK_BIT]
      |=> cfg_one_q[MONITOR_START_BIT] == $past(reg_wdata[MONITOR_START_BIT])
          && cfg_one_q[7:2] == $past(cfg_one_q[7:2]))
      else $error("locked config lost start write or changed locked bits");
   full_duty_a: assert property (
      wr_cfg_one && !reg_wdata[MONITOR_START_BIT] |=> fan_full_duty)
      else $error("fans not at full duty after monitoring stopped");
   twelve_sticky_a: assert property (
      flags_q[0] && status_read && twelve_volt_violation
      && !id_reg_q[SHARED_PIN_SELECT_BIT] |=> flags_q[0])
      else $error("12 V flag cleared while violation present");
   id_change_set_a: assert property (
      id_reg_q[SHARED_PIN_SELECT_BIT] && id_changed |=> flags_q[0])
      else $error("id change not flagged");
   overtemp_hold_a: assert property (
      flags_q[OVERTEMP_BIT] && status_read && !overtemp_below_hysteresis
      |=> flags_q[OVERTEMP_BIT])
      else $error("overtemp flag cleared above hysteresis");
   fan_off_a: assert property (
      !flags_q[FAN_ONE_BIT] && fan_drive_off[0] |=> !flags_q[FAN_ONE_BIT])
      else $error("fan one flag set while drive off");
   fan_clear_a: assert property (
      status_read && !fan_slow[0] |=> !flags_q[FAN_ONE_BIT])
      else $error("fan one flag survived read with fan ok");
   fan_four_off_a: assert property (
      !flags_q[5] && fan_drive_off[2] && fourth_pin_mode == PIN_TACH |=> !flags_q[5])
      else $error("fan four flag set while third drive off");
   pin_six_in_a: assert property (
      status_read && fourth_pin_mode == PIN_GPIO_IN
      |=> reg_rdata_q[5] == $past(general_pin_six_in))
      else $error("pin six input not read back");
   timer_set_a: assert property (
      fourth_pin_mode == PIN_THERMAL_TIMER && thermal_timer_over |=> flags_q[5])
      else $error("thermal timer flag not set");
   diode_hold_a: assert property (
      flags_q[DIODE_TWO_BIT] && !status_read |=> flags_q[DIODE_TWO_BIT])
      else $error("diode two flag dropped without a read");
   id_pins_read_a: assert property (
      reg_rd && reg_addr == VOLTAGE_ID_GPIO_ADDR
      |=> reg_rdata_q[4:0] == $past(voltage_id_in[4:0]))
      else $error("low id bits do not show pins");
   id_top_zero_a: assert property (
      reg_rd && reg_addr == VOLTAGE_ID_GPIO_ADDR && !id_reg_q[SHARED_PIN_SELECT_BIT]
      |=> !reg_rdata_q[ID_TOP_BIT])
      else $error("top id bit not zero when unselected");
   summary_read_a: assert property (
      out_of_limit_summary && status_read |=> reg_rdata_q != 8'h00)
      else $error("summary set but status reads zero");
   // fresh conditions and pin six writes must latch on the very next edge
   twelve_set_a: assert property (
      !id_reg_q[SHARED_PIN_SELECT_BIT] && twelve_volt_violation |=> flags_q[0])
      else $error("12 V flag not set on violation");
   overtemp_set_a: assert property (
      overtemp_exceeded |=> flags_q[OVERTEMP_BIT])
      else $error("overtemp flag not set");
   fan_two_set_a: assert property (
      fan_slow[1] && !fan_drive_off[1] |=> flags_q[FAN_ONE_BIT + 1])
      else $error("fan two flag not set while driven");
   diode_one_set_a: assert property (
      diode_fault[0] |=> flags_q[DIODE_ONE_BIT])
      else $error("diode one fault not flagged");
   pin_six_write_a: assert property (
      reg_wr && reg_addr == FAULT_STATUS_SECOND_ADDR && fourth_pin_mode == PIN_GPIO_OUT
      |=> general_pin_six_out == $past(reg_wdata[FOURTH_FAN_OR_PIN_BIT]))
      else $error("pin six output does not follow write");
   // in tach mode every latched flag must reach the summary
   summary_set_a: assert property (
      flags_q != 8'h00 && fourth_pin_mode == PIN_TACH |-> out_of_limit_summary)
      else $error("summary clear while a flag is latched");

   read_clear_c: cover property (flags_q[FAN_ONE_BIT] && status_read ##1 !flags_q[FAN_ONE_BIT]);
   id_change_c: cover property (id_reg_q[SHARED_PIN_SELECT_BIT] && id_changed ##1 id_change_alert);
   lock_write_c: cover property (wr_cfg_one && cfg_one_q[CFG_LOCK_BIT]);
   gpio_in_read_c: cover property (status_read && fourth_pin_mode == PIN_GPIO_IN);
   timer_flag_c: cover property (fourth_pin_mode == PIN_THERMAL_TIMER && flags_q[5]);
endmodule // fault_status_and_vid_port

/* tb/vid_pins_model.sv */
// pin-side model of the processor voltage-id lines and general pin six
module vid_pins_model
   import fault_vid_pkg::*;
(
   // pins driven by the device
   input wire logic [4:0] id_out,
   input wire logic [4:0] id_oe,
   input wire logic six_out,
   input wire logic six_oe,
   // levels the processor and the board put on the lines
   input wire logic [5:0] cpu_id,
   input wire logic six_ext,
   // resolved pin levels seen by the device
   output logic [5:0] id_pins,
   output logic six_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   assign id_pins = {cpu_id[5], (id_oe & id_out) | (~id_oe & cpu_id[4:0])};
   assign six_pin = six_oe ? six_out : six_ext;
endmodule // vid_pins_model

/* tb/tb_fault_status_and_vid_port.sv */
// self-checking bench for the fault status and voltage-id register bank
module tb_fault_status_and_vid_port
   import fault_vid_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata_q;
   logic twelve_volt_violation = 1'b0;
   logic overtemp_exceeded = 1'b0;
   logic overtemp_below_hysteresis = 1'b0;
   logic [3:0] fan_slow = 4'h0;
   logic [2:0] fan_drive_off = 3'h0;
   logic thermal_timer_over = 1'b0;
   logic [1:0] diode_fault = 2'h0;
   pin_mode_t fourth_pin_mode = PIN_TACH;
   logic [5:0] cpu_id = 6'h15;
   logic six_ext = 1'b0;
   logic [5:0] voltage_id_in;
   logic [4:0] voltage_id_out;
   logic [4:0] voltage_id_oe;
   logic general_pin_six_in;
   logic general_pin_six_out;
   logic general_pin_six_oe;
   logic monitor_start;
   logic fan_full_duty;
   logic id_threshold_select;
   logic shared_pin_function_select;
   logic out_of_limit_summary;
   logic id_change_alert;
   int num_errors = 0;
   int n_tests = 0;
   logic [7:0] d;
   logic [4:0] v;
   int k;

   always #50 ref_clk = ~ref_clk;

   fault_status_and_vid_port fault_status_and_vid_port_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .twelve_volt_violation(twelve_volt_violation),
      .overtemp_exceeded(overtemp_exceeded),
      .overtemp_below_hysteresis(overtemp_below_hysteresis), .fan_slow(fan_slow),
      .fan_drive_off(fan_drive_off), .thermal_timer_over(thermal_timer_over),
      .diode_fault(diode_fault), .fourth_pin_mode(fourth_pin_mode),
      .voltage_id_in(voltage_id_in), .voltage_id_out(voltage_id_out),
      .voltage_id_oe(voltage_id_oe), .general_pin_six_in(general_pin_six_in),
      .general_pin_six_out(general_pin_six_out), .general_pin_six_oe(general_pin_six_oe),
      .monitor_start(monitor_start), .fan_full_duty(fan_full_duty),
      .id_threshold_select(id_threshold_select),
      .shared_pin_function_select(shared_pin_function_select),
      .out_of_limit_summary(out_of_limit_summary), .id_change_alert(id_change_alert));

   vid_pins_model vid_pins_model_inst (.id_out(voltage_id_out), .id_oe(voltage_id_oe),
      .six_out(general_pin_six_out), .six_oe(general_pin_six_oe), .cpu_id(cpu_id),
      .six_ext(six_ext), .id_pins(voltage_id_in), .six_pin(general_pin_six_in));

   task automatic complete_run();
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   // one strobe per call; the leading wait keeps strobes apart in time
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      q = reg_rdata_q;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = w;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   // fan four shares drive three
   function automatic logic exp_fan(input int i, input logic [2:0] off);
      return (i < 3) ? !off[i] : !off[2];
   endfunction

   initial begin
      #5ms;
      num_errors++;
      complete_run();
   end

   initial begin
      void'($urandom(94));
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      rd(8'h42, d);
      chk("status reset", 8'h00, d);
      rd(8'h43, d);
      chk("id read", {3'b000, cpu_id[4:0]}, d);
      chk("id out reset", 8'h1f, voltage_id_out);
      chk("full duty idle", 8'h01, fan_full_duty);
      wr(8'h40, 8'h03);
      chk("full duty run", 8'h00, fan_full_duty);
      wr(8'h40, 8'h02);
      chk("start after lock", 8'h00, monitor_start);
      wr(8'h40, 8'h01);
      chk("start relocked", 8'h01, monitor_start);
      for (k = 0; k < 12; k++) begin
         fan_drive_off = 3'($urandom);
         fan_slow[k % 4] = 1'b1;
         @(negedge ref_clk);
         fan_slow = 4'h0;
         @(negedge ref_clk);
         chk("summary", 8'(exp_fan(k % 4, fan_drive_off)), out_of_limit_summary);
         rd(8'h42, d);
         chk("fan flag", 8'(exp_fan(k % 4, fan_drive_off)) << (2 + k % 4), d);
         rd(8'h42, d);
         chk("fan cleared", 8'h00, d);
      end
      fan_drive_off = 3'h0;
      twelve_volt_violation = 1'b1;
      overtemp_exceeded = 1'b1;
      diode_fault = 2'h3;
      @(negedge ref_clk);
      overtemp_exceeded = 1'b0;
      diode_fault = 2'h0;
      rd(8'h42, d);
      chk("held faults", 8'hc3, d);
      rd(8'h42, d);
      chk("not cleared", 8'h03, d);
      twelve_volt_violation = 1'b0;
      overtemp_below_hysteresis = 1'b1;
      rd(8'h42, d);
      rd(8'h42, d);
      chk("cleared", 8'h00, d);
      fourth_pin_mode = PIN_THERMAL_TIMER;
      thermal_timer_over = 1'b1;
      @(negedge ref_clk);
      thermal_timer_over = 1'b0;
      rd(8'h42, d);
      chk("timer flag", 8'h20, d);
      fourth_pin_mode = PIN_GPIO_OUT;
      wr(8'h42, 8'h20);
      chk("pin six out", 8'h03, {general_pin_six_oe, general_pin_six_out});
      fourth_pin_mode = PIN_GPIO_IN;
      six_ext = 1'($urandom);
      rd(8'h42, d);
      chk("pin six in", {2'b00, six_ext, 5'h00}, d & 8'h20);
      fourth_pin_mode = PIN_TACH;
      wr(8'h43, 8'hc0);
      chk("id controls", 8'h03,
          {shared_pin_function_select, id_threshold_select});
      cpu_id = 6'($urandom) | 6'h20;
      repeat (120) @(negedge ref_clk);
      rd(8'h42, d);
      rd(8'h42, d);
      rd(8'h43, d);
      chk("id top bit", {2'b11, cpu_id}, d);
      cpu_id[2] = ~cpu_id[2];
      for (k = 0; k < 115 && id_change_alert !== 1'b1; k++) @(negedge ref_clk);
      chk("id alert", 8'h01, id_change_alert);
      rd(8'h42, d);
      chk("id change flag", 8'h01, d);
      // low id bits as outputs; reads come back through the pins
      v = 5'($urandom);
      wr(8'h7c, 8'h10);
      wr(8'h43, {3'b000, v});
      chk("id oe", 8'h1f, voltage_id_oe);
      rd(8'h43, d);
      chk("id gpio", {3'b000, v}, d);
      // reset in mid-run brings back the power-on controls
      rst_n = 1'b0;
      @(negedge ref_clk);
      rst_n = 1'b1;
      chk("oe after reset", 8'h00, voltage_id_oe);
      chk("duty after reset", 8'h01, fan_full_duty);
      rd(8'h43, d);
      chk("id after reset", {3'b000, cpu_id[4:0]}, d);
      complete_run();
   end
endmodule // tb_fault_status_and_vid_port
